// *** obc_option_byte_config_decoder.sv ***
// obc_option_byte_config_decoder.sv: option byte store, programming port, decode
// assumes: programming tool drives port synchronous to clk in programming mode
//
// Behaviour
// - erased option bytes hold all ones; every option defaults to its one meaning
// - bytes reachable only from the programming-mode tool port, not software
// - byte0 bit7 one resets on halt entry while watchdog runs
// - byte0 bit6 zero makes watchdog hardware-enabled, one software-enabled
// - byte0 bit5 zero selects pll clock, one oscillator clock
// - byte0 bits4:3: 00 both detectors, 01 low-voltage only, 10 none
// - byte0 bit2 zero gives 4096 cycle reset delay, one gives 256
// - pll clock selection forces the 4096 cycle delay
// - byte0 bit1 zero enables oscillator divide-by-two, one bypasses
// - byte0 bit0 zero blocks memory reads, flash writes and option byte writes; tool reads of the bytes still work
// - erasing protected bytes first wipes all user memory, then allows writes
// - byte1 bits7:5 pick 32,44,56,64 pins; top bit set picks 80
// - byte1 bits1:0: 01 low, 10 high, 00/11 released under reset
`timescale 1ns/10ps
`include "obc_map.svh"
module obc_option_byte_config_decoder (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              clkEn,
  input  wire logic              progMode,
  input  wire logic              progWrite,
  input  wire logic              progRead,
  input  wire logic              progErase,
  input  wire logic              progSel,
  input  wire logic [7:0]        progWdata,
  output logic      [7:0]        progRdata,
  output logic                   progBusy,
  output logic                   userMemWipe,
  input  wire logic              userMemWipeDone,
  output logic                   flashWriteBlock,
  output logic                   memReadBlock,
  output obc_pkg::obc_cfg_s      cfg
);
  obc_pkg::obc_state_s state;
  obc_pkg::obc_state_s next_state;
  obc_pkg::obc_cfg_s   decoded;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  obc_decode u_decode (
    .byteZero (state.optionByteZero),
    .byteOne  (state.optionByteOne),
    .cfg      (decoded)
  );

  // ------------------------------------------------------------
  // programming port and erase sequence
  // ------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_state.cfg = decoded;
    unique case (state.progState)
      obc_pkg::OBC_IDLE: begin
        if (progMode && progErase) begin
          if (state.cfg.readoutProtect) begin
            next_state.progState = obc_pkg::OBC_WIPE;
          end else begin
            next_state.optionByteZero = `OBC_ERASED_VALUE;
            next_state.optionByteOne  = `OBC_ERASED_VALUE;
          end
        end else if (progMode && progWrite && !state.cfg.readoutProtect) begin
          if (progSel) begin
            next_state.optionByteOne = progWdata;
          end else begin
            next_state.optionByteZero = progWdata;
          end
        end else if (progMode && progRead) begin
          next_state.readData = progSel ? state.optionByteOne : state.optionByteZero;
        end
      end
      obc_pkg::OBC_WIPE: begin
        if (userMemWipeDone) begin
          next_state.optionByteZero = `OBC_ERASED_VALUE;
          next_state.optionByteOne  = `OBC_ERASED_VALUE;
          next_state.progState      = obc_pkg::OBC_WRITE;
        end
      end
      obc_pkg::OBC_WRITE: begin
        next_state.progState = obc_pkg::OBC_IDLE;
      end
      default: next_state.progState = obc_pkg::OBC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.optionByteZero <= `OBC_ERASED_VALUE;
      state.optionByteOne  <= `OBC_ERASED_VALUE;
      state.progState      <= obc_pkg::OBC_IDLE;
      state.cfg            <= '0;
      state.readData       <= 8'h00;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign progRdata       = state.readData;
  assign progBusy        = state.progState != obc_pkg::OBC_IDLE;
  assign userMemWipe     = state.progState == obc_pkg::OBC_WIPE;
  assign flashWriteBlock = state.cfg.readoutProtect;
  assign memReadBlock    = state.cfg.readoutProtect;
  assign cfg             = state.cfg;

  // ------------------------------------------------------------
  // checks: programming port
  // ------------------------------------------------------------
  // refused write leaves both bytes alone
  a_protect_blocks_write: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progWrite && !progErase && state.cfg.readoutProtect &&
    state.progState == obc_pkg::OBC_IDLE
    |=> $stable(state.optionByteZero) && $stable(state.optionByteOne))
    else $error("write changed bytes under protection");
  // accepted write lands in the selected byte only
  a_write_lands_zero: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progWrite && !progErase && !progSel &&
    !state.cfg.readoutProtect && state.progState == obc_pkg::OBC_IDLE
    |=> state.optionByteZero == $past(progWdata) && $stable(state.optionByteOne))
    else $error("write to byte zero lost");
  a_write_lands_one: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progWrite && !progErase && progSel &&
    !state.cfg.readoutProtect && state.progState == obc_pkg::OBC_IDLE
    |=> state.optionByteOne == $past(progWdata) && $stable(state.optionByteZero))
    else $error("write to byte one lost");
  // read answer shows the selected byte
  a_read_byte_zero: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progRead && !progWrite && !progErase && !progSel &&
    state.progState == obc_pkg::OBC_IDLE
    |=> progRdata == $past(state.optionByteZero))
    else $error("read of byte zero wrong");
  a_read_byte_one: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progRead && !progWrite && !progErase && progSel &&
    state.progState == obc_pkg::OBC_IDLE
    |=> progRdata == $past(state.optionByteOne))
    else $error("read of byte one wrong");
  // outside programming mode, with no wipe running, both bytes hold
  a_no_mode_no_write: assert property (@(posedge clk) disable iff (!resetn)
    !progMode && !userMemWipe
    |=> $stable(state.optionByteZero) && $stable(state.optionByteOne))
    else $error("bytes changed outside programming mode");
  // clock enable low freezes every flop
  a_enable_freezes: assert property (@(posedge clk) disable iff (!resetn)
    !clkEn |=> $stable(state))
    else $error("state moved with clock enable low");

  // ------------------------------------------------------------
  // checks: erase sequence
  // ------------------------------------------------------------
  // protected erase wipes user memory before touching the bytes
  a_erase_wipes_first: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progErase && state.cfg.readoutProtect &&
    state.progState == obc_pkg::OBC_IDLE
    |=> userMemWipe && $stable(state.optionByteZero) && $stable(state.optionByteOne))
    else $error("protected erase skipped wipe");
  // bytes hold while the wipe runs
  a_wipe_holds_bytes: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && userMemWipe && !userMemWipeDone
    |=> userMemWipe && $stable(state.optionByteZero) && $stable(state.optionByteOne))
    else $error("bytes moved during wipe");
  a_wipe_then_erased: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && userMemWipe && userMemWipeDone |=> !userMemWipe &&
    state.optionByteZero == `OBC_ERASED_VALUE && state.optionByteOne == `OBC_ERASED_VALUE)
    else $error("bytes not erased after wipe");
  // unprotected erase goes straight to the erased value
  a_plain_erase: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && progMode && progErase && !state.cfg.readoutProtect &&
    state.progState == obc_pkg::OBC_IDLE
    |=> !userMemWipe && state.optionByteZero == `OBC_ERASED_VALUE &&
    state.optionByteOne == `OBC_ERASED_VALUE)
    else $error("plain erase left bytes programmed");

  // ------------------------------------------------------------
  // checks: decoded settings
  // ------------------------------------------------------------
  // single-bit options follow their bit one cycle later
  a_halt_follows: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> cfg.haltResetSelect == $past(state.optionByteZero[`OBC_B0_HALT_RST]))
    else $error("halt reset select wrong");
  a_watchdog_type: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> cfg.watchdogHardware != $past(state.optionByteZero[`OBC_B0_WDG_TYPE]))
    else $error("watchdog type wrong");
  a_clock_source: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> cfg.pllSelected != $past(state.optionByteZero[`OBC_B0_CLK_SRC]))
    else $error("clock source wrong");
  a_halver_follows: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> cfg.oscillatorHalver != $past(state.optionByteZero[`OBC_B0_OSC_HALF]))
    else $error("oscillator halver wrong");
  a_protect_follows: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> cfg.readoutProtect != $past(state.optionByteZero[`OBC_B0_RD_PROT]) &&
    flashWriteBlock == cfg.readoutProtect && memReadBlock == cfg.readoutProtect)
    else $error("protection flags wrong");
  // detector enable codes
  a_detect_both_on: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteZero[`OBC_B0_VD_HI:`OBC_B0_VD_LO] == 2'h0
    |=> cfg.lowVoltageDetector && cfg.auxiliaryVoltageDetector)
    else $error("detectors not both on");
  a_detect_low_only: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteZero[`OBC_B0_VD_HI:`OBC_B0_VD_LO] == 2'h1
    |=> cfg.lowVoltageDetector && !cfg.auxiliaryVoltageDetector)
    else $error("low-voltage-only code wrong");
  a_detect_both_off: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteZero[`OBC_B0_VD_HI]
    |=> !cfg.lowVoltageDetector && !cfg.auxiliaryVoltageDetector)
    else $error("detector on with code 1x");
  // reset phase length
  a_pll_long_delay: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && !state.optionByteZero[`OBC_B0_CLK_SRC]
    |=> cfg.resetDelayCycles == `OBC_LONG_DELAY)
    else $error("pll did not force long delay");
  a_long_delay: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && !state.optionByteZero[`OBC_B0_RST_CYC]
    |=> cfg.resetDelayCycles == `OBC_LONG_DELAY)
    else $error("long delay not decoded");
  a_short_delay: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteZero[`OBC_B0_CLK_SRC] && state.optionByteZero[`OBC_B0_RST_CYC]
    |=> cfg.resetDelayCycles == `OBC_SHORT_DELAY)
    else $error("short delay not decoded");
  // package pin count
  a_pins_wide: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteOne[`OBC_B1_PKG_HI] |=> cfg.packagePins == `OBC_PINS_80)
    else $error("top package bit not 80 pins");
  a_pins_narrow: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteOne[`OBC_B1_PKG_HI:`OBC_B1_PKG_LO] == 3'h0
    |=> cfg.packagePins == `OBC_PINS_32)
    else $error("package code 000 not 32 pins");
  // motor outputs under reset
  a_motor_high: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteOne[`OBC_B1_MCO_HI:`OBC_B1_MCO_LO] == 2'h2
    |=> cfg.motorOutputEnable && cfg.motorOutputLevel)
    else $error("motor output not high");
  a_motor_low: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteOne[`OBC_B1_MCO_HI:`OBC_B1_MCO_LO] == 2'h1
    |=> cfg.motorOutputEnable && !cfg.motorOutputLevel)
    else $error("motor output not low");
  a_motor_released: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && state.optionByteOne[`OBC_B1_MCO_HI] == state.optionByteOne[`OBC_B1_MCO_LO]
    |=> !cfg.motorOutputEnable)
    else $error("motor output driven for 00 or 11");

  // ------------------------------------------------------------
  // coverage of the main scenarios
  // ------------------------------------------------------------
  c_protected_erase: cover property (@(posedge clk) userMemWipe ##1 !userMemWipe);
  c_write_byte_one: cover property (@(posedge clk) progMode && progWrite && progSel);
  c_pll_selected: cover property (@(posedge clk) cfg.pllSelected);
  c_refused_write: cover property (@(posedge clk) progMode && progWrite && cfg.readoutProtect);
  c_enable_low: cover property (@(posedge clk) !clkEn && progMode && progWrite);
endmodule // obc_option_byte_config_decoder

// *** obc_map.svh ***
// obc_map.svh: option byte field positions, reset values and delay counts
// assumes: included by the package and design files by bare name
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH
`define OBC_ERASED_VALUE   8'hff
`define OBC_B0_HALT_RST    7
`define OBC_B0_WDG_TYPE    6
`define OBC_B0_CLK_SRC     5
`define OBC_B0_VD_HI       4
`define OBC_B0_VD_LO       3
`define OBC_B0_RST_CYC     2
`define OBC_B0_OSC_HALF    1
`define OBC_B0_RD_PROT     0
`define OBC_B1_PKG_HI      7
`define OBC_B1_PKG_LO      5
`define OBC_B1_MCO_HI      1
`define OBC_B1_MCO_LO      0
`define OBC_LONG_DELAY     13'h1000
`define OBC_SHORT_DELAY    13'h0100
`define OBC_PINS_32        7'h20
`define OBC_PINS_44        7'h2c
`define OBC_PINS_56        7'h38
`define OBC_PINS_64        7'h40
`define OBC_PINS_80        7'h50
`endif

// *** obc_pkg.sv ***
// obc_pkg.sv: types shared by the option byte decoder
// assumes: obc_map.svh is on the include path
`include "obc_map.svh"
package obc_pkg;
  typedef enum logic [2:0] {
    OBC_IDLE  = 3'b001,
    OBC_WIPE  = 3'b010,
    OBC_WRITE = 3'b100
  } obc_prog_e;

  typedef struct packed {
    logic        haltResetSelect;
    logic        watchdogHardware;
    logic        pllSelected;
    logic        lowVoltageDetector;
    logic        auxiliaryVoltageDetector;
    logic [12:0] resetDelayCycles;
    logic        oscillatorHalver;
    logic        readoutProtect;
    logic [6:0]  packagePins;
    logic        motorOutputEnable;
    logic        motorOutputLevel;
  } obc_cfg_s;

  typedef struct packed {
    logic [7:0] optionByteZero;
    logic [7:0] optionByteOne;
    obc_prog_e  progState;
    obc_cfg_s   cfg;
    logic [7:0] readData;
  } obc_state_s;
endpackage

// *** obc_decode.sv ***
// obc_decode.sv: combinational decode of both option bytes into settings
// assumes: bytes come from the storage flops of the top module
`timescale 1ns/10ps
`include "obc_map.svh"
module obc_decode (
  input  wire logic [7:0]       byteZero,
  input  wire logic [7:0]       byteOne,
  output obc_pkg::obc_cfg_s     cfg
);
  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  always_comb begin
    cfg                  = '0;
    cfg.haltResetSelect  = byteZero[`OBC_B0_HALT_RST];
    cfg.watchdogHardware = ~byteZero[`OBC_B0_WDG_TYPE];
    cfg.pllSelected      = ~byteZero[`OBC_B0_CLK_SRC];
    // detector enables; code 11 acts as 10
    unique case (byteZero[`OBC_B0_VD_HI:`OBC_B0_VD_LO])
      2'h0: begin
        cfg.lowVoltageDetector       = 1'b1;
        cfg.auxiliaryVoltageDetector = 1'b1;
      end
      2'h1: begin
        cfg.lowVoltageDetector       = 1'b1;
        cfg.auxiliaryVoltageDetector = 1'b0;
      end
      2'h2, 2'h3: begin
        cfg.lowVoltageDetector       = 1'b0;
        cfg.auxiliaryVoltageDetector = 1'b0;
      end
    endcase
    // pll forces the long delay
    if (!byteZero[`OBC_B0_CLK_SRC] || !byteZero[`OBC_B0_RST_CYC]) begin
      cfg.resetDelayCycles = `OBC_LONG_DELAY;
    end else begin
      cfg.resetDelayCycles = `OBC_SHORT_DELAY;
    end
    cfg.oscillatorHalver = ~byteZero[`OBC_B0_OSC_HALF];
    cfg.readoutProtect   = ~byteZero[`OBC_B0_RD_PROT];
    if (byteOne[`OBC_B1_PKG_HI]) begin
      cfg.packagePins = `OBC_PINS_80;
    end else begin
      unique case (byteOne[`OBC_B1_PKG_HI-1:`OBC_B1_PKG_LO])
        2'h0: cfg.packagePins = `OBC_PINS_32;
        2'h1: cfg.packagePins = `OBC_PINS_44;
        2'h2: cfg.packagePins = `OBC_PINS_56;
        2'h3: cfg.packagePins = `OBC_PINS_64;
      endcase
    end
    // motor outputs under reset: 01 low, 10 high, else released
    cfg.motorOutputEnable = byteOne[`OBC_B1_MCO_HI] ^ byteOne[`OBC_B1_MCO_LO];
    cfg.motorOutputLevel  = byteOne[`OBC_B1_MCO_HI];
  end
endmodule // obc_decode

// *** obc_prog_tool.sv ***
// obc_prog_tool.sv: programming tool model for the option byte port
// assumes: bench calls req; signals change 1 ns after the rising clk edge
`timescale 1ns/10ps
module obc_prog_tool (
  input  wire logic       clk,
  input  wire logic       userMemWipe,
  output logic            progMode = 1'b0,
  output logic            progWrite = 1'b0,
  output logic            progRead = 1'b0,
  output logic            progErase = 1'b0,
  output logic            progSel = 1'b0,
  output logic [7:0]      progWdata = 8'h00,
  output logic            userMemWipeDone = 1'b0
);
  int wipeCnt = 0;

  // one request held across one edge; kind is {erase, write, read}
  task automatic req(input logic m, input logic [2:0] kind, input logic s,
                     input logic [7:0] d);
    @(posedge clk);
    #1;
    progMode = m;
    {progErase, progWrite, progRead} = kind;
    progSel = s;
    progWdata = d;
    @(posedge clk);
    #1;
    {progMode, progErase, progWrite, progRead} = 4'h0;
    progWdata = ~d; // released data keeps no stale value
  endtask

  // memory wipe ends a few cycles after it is asked for
  always @(posedge clk) begin
    wipeCnt <= userMemWipe ? wipeCnt + 1 : 0;
    userMemWipeDone <= #1 (userMemWipe && wipeCnt >= 4);
  end
endmodule // obc_prog_tool

// *** tb_option_byte_config_decoder.sv ***
// tb_option_byte_config_decoder.sv: self-checking bench for the option byte decoder
// assumes: obc_pkg and obc_prog_tool compiled first
`timescale 1ns/10ps
module tb_option_byte_config_decoder;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              clkEn = 1'b1;
  logic              progMode, progWrite, progRead, progErase, progSel, userMemWipeDone;
  logic [7:0]        progWdata, progRdata;
  logic              progBusy, userMemWipe, flashWriteBlock, memReadBlock;
  obc_pkg::obc_cfg_s cfg;
  int                bad_count = 0;
  int                n_compared = 0;
  int                seed = 13;
  logic [7:0]        mb [2] = '{8'hff, 8'hff};

  initial forever #20 clk = ~clk;

  obc_option_byte_config_decoder i_obc_option_byte_config_decoder (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .progMode(progMode),
    .progWrite(progWrite), .progRead(progRead), .progErase(progErase),
    .progSel(progSel), .progWdata(progWdata), .progRdata(progRdata),
    .progBusy(progBusy), .userMemWipe(userMemWipe), .userMemWipeDone(userMemWipeDone),
    .flashWriteBlock(flashWriteBlock), .memReadBlock(memReadBlock), .cfg(cfg));
  obc_prog_tool i_obc_prog_tool (
    .clk(clk), .userMemWipe(userMemWipe), .progMode(progMode), .progWrite(progWrite),
    .progRead(progRead), .progErase(progErase), .progSel(progSel),
    .progWdata(progWdata), .userMemWipeDone(userMemWipeDone));

  // expected settings from the two bytes
  function automatic obc_pkg::obc_cfg_s expect_cfg(input logic [7:0] b0, input logic [7:0] b1);
    obc_pkg::obc_cfg_s e;
    logic [6:0] pins [4] = '{7'h20, 7'h2c, 7'h38, 7'h40};
    e.haltResetSelect = b0[7];
    e.watchdogHardware = ~b0[6];
    e.pllSelected = ~b0[5];
    e.lowVoltageDetector = (b0[4:3] <= 2'h1);
    e.auxiliaryVoltageDetector = (b0[4:3] == 2'h0);
    e.resetDelayCycles = (b0[2] && b0[5]) ? 13'h0100 : 13'h1000;
    e.oscillatorHalver = ~b0[1];
    e.readoutProtect = ~b0[0];
    e.packagePins = b1[7] ? 7'h50 : pins[b1[6:5]];
    e.motorOutputEnable = (b1[1:0] == 2'h1) || (b1[1:0] == 2'h2);
    e.motorOutputLevel = e.motorOutputEnable & b1[1];
    return e;
  endfunction

  // settings and protection flags against the model
  task automatic cmp_cfg();
    obc_pkg::obc_cfg_s e, a;
    e = expect_cfg(mb[0], mb[1]);
    a = cfg;
    if (!e.motorOutputEnable) a.motorOutputLevel = 1'b0; // level is free while released
    n_compared++;
    if (a !== e || {flashWriteBlock, memReadBlock} !== {2{e.readoutProtect}}) begin
      bad_count++;
      $display("wrong value at %0t: cfg %h expected %h", $time, a, e);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, act, exp);
    end
  endtask

  // write; m low models a request outside programming mode
  task automatic wr(input logic m, input logic s, input logic [7:0] d);
    i_obc_prog_tool.req(m, 3'h2, s, d);
    if (m && mb[0][0]) mb[s] = d;
    repeat (2) @(posedge clk);
    #2;
    cmp_cfg();
  endtask

  // write with the clock enable low: nothing may move
  task automatic wr_frozen(input logic [7:0] d);
    @(posedge clk);
    #1 clkEn = 1'b0;
    i_obc_prog_tool.req(1'b1, 3'h2, 1'b0, d);
    repeat (2) @(posedge clk);
    #2;
    cmp_cfg();
    @(posedge clk);
    #1 clkEn = 1'b1;
  endtask

  task automatic rd(input logic s);
    i_obc_prog_tool.req(1'b1, 3'h1, s, 8'h00);
    @(posedge clk);
    #2;
    cmp_byte(progRdata, mb[s]);
  endtask

  task automatic erase();
    logic prot;
    prot = ~mb[0][0];
    i_obc_prog_tool.req(1'b1, 3'h4, 1'b0, 8'h00);
    cmp_byte({7'h0, userMemWipe}, {7'h0, prot});
    cmp_byte({7'h0, progBusy}, {7'h0, prot});
    mb = '{8'hff, 8'hff};
    for (int k = 0; k < 100 && progBusy !== 1'b0; k++) @(posedge clk);
    cmp_byte({7'h0, progBusy}, 8'h00);
    repeat (2) @(posedge clk);
    #2;
    cmp_cfg();
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    cmp_cfg();
    rd(1'b0);
    wr(1'b1, 1'b0, 8'hdf);
    wr(1'b1, 1'b0, 8'hfb);
    wr(1'b0, 1'b0, 8'h03);
    for (int i = 0; i < 40; i++) begin
      wr(1'b1, 1'(i), 8'($random(seed)) | {7'h00, ~i[0]});
      rd(1'(i));
    end
    wr_frozen(8'h00);
    // mid-run reset brings the bytes back to erased
    @(posedge clk);
    #1 resetn = 1'b0;
    mb = '{8'hff, 8'hff};
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    cmp_cfg();
    wr(1'b1, 1'b0, 8'hfe);
    wr(1'b1, 1'b1, 8'h00);
    rd(1'b1);
    erase();
    erase();
    end_sim();
  end
endmodule // tb_option_byte_config_decoder
